// >>> src/vic_pkg.sv
// Shared constants and types of the vectored interrupt controller
package vic_pkg;

   // ********************
   // Operating option register
   // ********************
   typedef struct packed {
      logic master_en;
      logic [1:0] rd_sel;
      logic req_rise;
      logic irq_high;
      logic polled;
      logic common_vec;
      logic rotate;
   } vic_mode_t;

   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'hff;
   localparam logic [7:0] ALL_CLEAR = 8'h00;
   localparam logic [2:0] LAST_RESET = 3'h7;

   // Data read preselect codes held in mode bits 6:5
   localparam logic [1:0] RD_ISR = 2'h0;
   localparam logic [1:0] RD_IMR = 2'h1;
   localparam logic [1:0] RD_IRR = 2'h2;
   localparam logic [1:0] RD_ACR = 2'h3;

   // ********************
   // Command opcodes, upper nibble
   // ********************
   localparam logic [7:0] CMD_RESET = 8'h00;
   localparam logic [3:0] OP_CLR_IRR_IMR = 4'h1;
   localparam logic [3:0] OP_CLR_IMR = 4'h2;
   localparam logic [3:0] OP_SET_IMR = 4'h3;
   localparam logic [3:0] OP_CLR_IRR = 4'h4;
   localparam logic [3:0] OP_SET_IRR = 4'h5;
   localparam logic [3:0] OP_ISR = 4'h6;
   localparam logic [3:0] OP_ISR_SEL = 4'h7;
   localparam logic [3:0] OP_MODE_LO = 4'h8;
   localparam logic [3:0] OP_MODE_LO1 = 4'h9;
   localparam logic [3:0] OP_MODE_HI = 4'ha;
   localparam logic [3:0] OP_PRE_IMR = 4'hb;
   localparam logic [3:0] OP_PRE_ACR = 4'hc;
   localparam logic [3:0] OP_PRE_LVL = 4'he;
   localparam logic [3:0] OP_PRE_LVL1 = 4'hf;

   // Master enable sub-codes of the mode bits 5/6 command
   localparam logic [1:0] MM_SET = 2'h1;
   localparam logic [1:0] MM_CLR = 2'h2;

   // ********************
   // Data write targets
   // ********************
   typedef enum logic [1:0] {
      DW_NONE = 2'h0,
      DW_IMR = 2'h1,
      DW_ACR = 2'h2,
      DW_MEM = 2'h3
   } vic_dsel_t;

   // ********************
   // Acknowledge sequencer
   // ********************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SEL = 3'b010,
      ST_XFER = 3'b100
   } vic_state_t;

endpackage

// >>> src/vic_top.sv
// Eight-input vectored interrupt controller with byte-wide host port
// What this block does
// - Reset by power-up or command clears all registers, sets mask, keeps memory.
// - Active request edges latch into pending bits; unmasked ones raise group irq.
// - Acknowledge drops select wait, picks winner, drops in-progress, drives byte.
// - Select wait low until in-progress falls; in-progress low until last byte.
// - Selection clears the pending bit and sets the in-service bit.
// - Set in-service bit suppresses group irq unless higher priority pending.
// - Higher priority request re-raises group irq and nests in-service bits.
// - Control/data low: reads return preselected register, writes load the one chosen by preselect command.
// - Control/data high: reads return status, writes load command register.
// - With chip select high an acknowledge pulse drives a response byte.
// - Option bits 5/6 choose data read register; memory only via acknowledge.
// - Mask, auto-clear and response levels load only after preselect commands.
// - Operating options clear to zero on power-up and reset command.
// - Fixed priority: input 0 highest, input 7 lowest.
// - Rotating priority makes the last serviced request lowest.
// - Common vectoring always returns the response of input 0.
// - Polled mode: no group irq, pending bit kept on selection, chain out follows chain in.
// - Option bit 3 sets group irq polarity; active low is open drain.
// - Option bit 4 selects falling or rising request edge sense.
// - Master mask disables requests, forces chain out low outside polled mode, shows as status bit 3.
// - Each response length is a 2-bit count, one less than its number of acknowledge pulses.
// - Auto-clear bits clear in-service at sequence end; else software clears.
`timescale 1ns/1ps
`default_nettype none
module vic_top #(
   parameter int N_REQ = 8,
   parameter int N_BYTES = 4
) (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // Host bus port
   input wire logic i_cs_b,
   input wire logic i_cd,
   input wire logic i_rd_b,
   input wire logic i_wr_b,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe_b,
   // Acknowledge handshake
   input wire logic i_ack_strobe_b,
   output logic o_select_wait_b,
   output logic o_response_in_progress_b,
   // Requests and group interrupt
   input wire logic [N_REQ-1:0] i_request_in,
   output logic o_group_irq_out,
   output logic o_group_irq_oe_b,
   // Priority chain
   input wire logic i_chain_enable_in,
   output logic o_chain_enable_out
);

   // ********************
   // Storage
   // ********************
   logic [N_REQ-1:0] pending_request_reg;
   logic [N_REQ-1:0] in_service_reg;
   logic [N_REQ-1:0] request_mask_reg;
   logic [N_REQ-1:0] auto_clear_reg;
   vic_pkg::vic_mode_t operating_option_reg;
   vic_pkg::vic_dsel_t dsel;
   vic_pkg::vic_state_t state;
   logic [2:0] pre_lvl;
   logic [1:0] pre_ptr;
   logic [1:0] byte_count [N_REQ];
   logic [7:0] resp_mem [N_REQ][N_BYTES];
   logic [2:0] sel_lvl;
   logic sel_valid;
   logic [1:0] byte_idx;
   logic [2:0] last_lvl;
   logic [N_REQ-1:0] req_s1, req_s2, req_q;
   logic ack_s1, ack_s2, ack_q;
   logic wr_q;
   logic group_active;

   // ********************
   // Strobe and edge detection
   // ********************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         req_s1 <= '0;
         req_s2 <= '0;
         req_q <= '0;
         ack_s1 <= 1'b1;
         ack_s2 <= 1'b1;
         ack_q <= 1'b1;
         wr_q <= 1'b1;
      end else if (i_clk_en) begin
         req_s1 <= i_request_in;
         req_s2 <= req_s1;
         req_q <= req_s2;
         ack_s1 <= i_ack_strobe_b;
         ack_s2 <= ack_s1;
         ack_q <= ack_s2;
         wr_q <= i_wr_b;
      end
   end

   logic [N_REQ-1:0] req_edge;
   logic ack_fall, ack_rise, bus_wr, cmd_wr, data_wr;
   assign req_edge = operating_option_reg.req_rise ? (req_s2 & ~req_q) : (~req_s2 & req_q);
   assign ack_fall = i_cs_b && !ack_s2 && ack_q;
   assign ack_rise = ack_s2 && !ack_q;
   assign bus_wr = !i_cs_b && !i_wr_b && wr_q;
   assign cmd_wr = bus_wr && i_cd;
   assign data_wr = bus_wr && !i_cd;

   // ********************
   // Command decode
   // ********************
   logic [7:0] one_bit, cmd_sel;
   logic soft_rst;
   assign one_bit = 8'h01 << i_data[2:0];
   assign cmd_sel = i_data[3] ? one_bit : 8'hff;
   assign soft_rst = cmd_wr && (i_data == vic_pkg::CMD_RESET);

   logic [N_REQ-1:0] irr_clr, irr_set, imr_clr, imr_set, isr_clr;
   logic [N_REQ-1:0] isr_top_bit;
   always_comb begin
      irr_clr = '0;
      irr_set = '0;
      imr_clr = '0;
      imr_set = '0;
      isr_clr = '0;
      if (cmd_wr) begin
         case (i_data[7:4])
            vic_pkg::OP_CLR_IRR_IMR: begin
               irr_clr = cmd_sel;
               imr_clr = cmd_sel;
            end
            vic_pkg::OP_CLR_IMR: imr_clr = cmd_sel;
            vic_pkg::OP_SET_IMR: imr_set = cmd_sel;
            vic_pkg::OP_CLR_IRR: irr_clr = cmd_sel;
            vic_pkg::OP_SET_IRR: irr_set = cmd_sel;
            vic_pkg::OP_ISR: isr_clr = isr_top_bit;
            vic_pkg::OP_ISR_SEL: isr_clr = cmd_sel;
            default: irr_clr = '0;
         endcase
      end
   end

   // ********************
   // Priority resolution
   // ********************
   logic [N_REQ-1:0] eligible;
   logic [2:0] base, win_lvl, isr_top;
   logic win_any, isr_any, irq_hot;
   assign eligible = pending_request_reg & ~request_mask_reg
                     & {N_REQ{operating_option_reg.master_en}};
   assign base = operating_option_reg.rotate ? last_lvl + 3'h1 : 3'h0;
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      win_any = 1'b0;
      win_lvl = 3'h0;
      isr_any = 1'b0;
      isr_top = 3'h0;
      irq_hot = 1'b0;
      for (int i = 0; i < N_REQ; i++) begin
         idx = base + 3'(i);
         if (!isr_any && in_service_reg[idx]) begin
            isr_any = 1'b1;
            isr_top = idx;
         end
         if (!win_any && eligible[idx]) begin
            win_any = 1'b1;
            win_lvl = idx;
            irq_hot = !isr_any;
         end
      end
   end
   assign isr_top_bit = isr_any ? (8'h01 << isr_top) : 8'h00;

   // ********************
   // Acknowledge sequencer
   // ********************
   logic [2:0] vec_lvl;
   logic seq_end;
   logic [N_REQ-1:0] sel_bit;
   assign vec_lvl = operating_option_reg.common_vec ? 3'h0 : sel_lvl;
   assign seq_end = (state == vic_pkg::ST_XFER) && ack_rise
                    && (byte_idx == byte_count[vec_lvl]);
   assign sel_bit = 8'h01 << sel_lvl;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         state <= vic_pkg::ST_IDLE;
         sel_lvl <= 3'h0;
         sel_valid <= 1'b0;
         byte_idx <= 2'h0;
         last_lvl <= vic_pkg::LAST_RESET;
      end else if (i_clk_en) begin
         if (soft_rst) begin
            state <= vic_pkg::ST_IDLE;
            last_lvl <= vic_pkg::LAST_RESET;
         end else begin
            case (state)
               vic_pkg::ST_IDLE: begin
                  if (ack_fall) begin
                     state <= vic_pkg::ST_SEL;
                     sel_lvl <= win_lvl;
                     sel_valid <= win_any;
                     byte_idx <= 2'h0;
                     if (win_any) begin
                        last_lvl <= win_lvl;
                     end
                  end
               end
               vic_pkg::ST_SEL: state <= vic_pkg::ST_XFER;
               vic_pkg::ST_XFER: begin
                  if (seq_end) begin
                     state <= vic_pkg::ST_IDLE;
                  end else if (ack_rise) begin
                     byte_idx <= byte_idx + 2'h1;
                  end
               end
               default: state <= vic_pkg::ST_IDLE;
            endcase
         end
      end
   end

   logic hw_sel;
   assign hw_sel = (state == vic_pkg::ST_SEL) && sel_valid;

   // ********************
   // Pending, in-service, mask, auto-clear
   // ********************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         pending_request_reg <= vic_pkg::ALL_CLEAR;
      end else if (i_clk_en) begin
         if (soft_rst) begin
            pending_request_reg <= vic_pkg::ALL_CLEAR;
         end else begin
            pending_request_reg <= (pending_request_reg & ~irr_clr
               & ~((hw_sel && !operating_option_reg.polled) ? sel_bit : 8'h00))
               | irr_set | req_edge;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         in_service_reg <= vic_pkg::ALL_CLEAR;
      end else if (i_clk_en) begin
         if (soft_rst) begin
            in_service_reg <= vic_pkg::ALL_CLEAR;
         end else begin
            in_service_reg <= (in_service_reg & ~isr_clr
               & ~((seq_end && sel_valid) ? (sel_bit & auto_clear_reg) : 8'h00))
               | (hw_sel ? sel_bit : 8'h00);
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         request_mask_reg <= vic_pkg::MASK_RESET;
      end else if (i_clk_en) begin
         if (soft_rst) begin
            request_mask_reg <= vic_pkg::MASK_RESET;
         end else if (data_wr && dsel == vic_pkg::DW_IMR) begin
            request_mask_reg <= i_data;
         end else begin
            request_mask_reg <= (request_mask_reg & ~imr_clr) | imr_set;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         auto_clear_reg <= vic_pkg::ALL_CLEAR;
      end else if (i_clk_en) begin
         if (soft_rst) begin
            auto_clear_reg <= vic_pkg::ALL_CLEAR;
         end else if (data_wr && dsel == vic_pkg::DW_ACR) begin
            auto_clear_reg <= i_data;
         end
      end
   end

   // ********************
   // Operating options and preselection
   // ********************
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         operating_option_reg <= vic_pkg::MODE_RESET;
         dsel <= vic_pkg::DW_NONE;
         pre_lvl <= 3'h0;
         pre_ptr <= 2'h0;
      end else if (i_clk_en) begin
         if (soft_rst) begin
            operating_option_reg <= vic_pkg::MODE_RESET;
            dsel <= vic_pkg::DW_NONE;
         end else if (cmd_wr) begin
            case (i_data[7:4])
               vic_pkg::OP_MODE_LO, vic_pkg::OP_MODE_LO1: begin
                  operating_option_reg[4:0] <= i_data[4:0];
               end
               vic_pkg::OP_MODE_HI: begin
                  operating_option_reg.rd_sel <= i_data[3:2];
                  if (i_data[1:0] == vic_pkg::MM_SET) begin
                     operating_option_reg.master_en <= 1'b1;
                  end else if (i_data[1:0] == vic_pkg::MM_CLR) begin
                     operating_option_reg.master_en <= 1'b0;
                  end
               end
               vic_pkg::OP_PRE_IMR: dsel <= vic_pkg::DW_IMR;
               vic_pkg::OP_PRE_ACR: dsel <= vic_pkg::DW_ACR;
               vic_pkg::OP_PRE_LVL, vic_pkg::OP_PRE_LVL1: begin
                  dsel <= vic_pkg::DW_MEM;
                  pre_lvl <= i_data[2:0];
                  pre_ptr <= 2'h0;
               end
               default: dsel <= dsel;
            endcase
         end else if (data_wr && dsel == vic_pkg::DW_MEM) begin
            pre_ptr <= pre_ptr + 2'h1;
         end
      end
   end

   // Response memory and byte counts survive reset
   always_ff @(posedge i_sys_clk) begin
      if (i_clk_en) begin
         if (cmd_wr && i_data[7:5] == vic_pkg::OP_PRE_LVL[3:1]) begin
            byte_count[i_data[2:0]] <= i_data[4:3];
         end
         if (data_wr && dsel == vic_pkg::DW_MEM) begin
            resp_mem[pre_lvl][pre_ptr] <= i_data;
         end
      end
   end

   // ********************
   // Read data and outputs
   // ********************
   logic [7:0] status, reg_rd, next_data;
   logic rd_act, ack_act;
   assign status = {group_active, !win_any, operating_option_reg.polled,
                    operating_option_reg.rotate, operating_option_reg.master_en,
                    win_lvl};
   always_comb begin
      case (operating_option_reg.rd_sel)
         vic_pkg::RD_ISR: reg_rd = in_service_reg;
         vic_pkg::RD_IMR: reg_rd = request_mask_reg;
         vic_pkg::RD_IRR: reg_rd = pending_request_reg;
         default: reg_rd = auto_clear_reg;
      endcase
   end
   assign rd_act = !i_cs_b && !i_rd_b;
   assign ack_act = i_cs_b && !ack_s2 && (state == vic_pkg::ST_XFER);
   assign next_data = ack_act ? resp_mem[vec_lvl][byte_idx]
                      : (i_cd ? status : reg_rd);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_data <= 8'h00;
         o_data_oe_b <= 1'b1;
         group_active <= 1'b0;
      end else if (i_clk_en) begin
         o_data <= next_data;
         o_data_oe_b <= !(rd_act || ack_act);
         group_active <= irq_hot && !operating_option_reg.polled && !soft_rst;
      end
   end

   assign o_group_irq_out = operating_option_reg.irq_high && group_active;
   assign o_group_irq_oe_b = !operating_option_reg.irq_high && !group_active;
   assign o_select_wait_b = (state != vic_pkg::ST_SEL);
   assign o_response_in_progress_b = (state != vic_pkg::ST_XFER);
   assign o_chain_enable_out = operating_option_reg.polled ? i_chain_enable_in
                               : (i_chain_enable_in && operating_option_reg.master_en);

endmodule
`default_nettype wire

// >>> test/vic_top_asserts.sv
// Port-level assertions of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_top_asserts #(
   parameter int N_REQ = 8
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Host strobes
   input wire logic i_cs_b,
   input wire logic i_rd_b,
   input wire logic i_ack_strobe_b,
   input wire logic i_chain_enable_in,
   // Device outputs
   input wire logic o_data_oe_b,
   input wire logic o_select_wait_b,
   input wire logic o_response_in_progress_b,
   input wire logic o_group_irq_out,
   input wire logic o_group_irq_oe_b,
   input wire logic o_chain_enable_out
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_b);

   // ********************
   // Acknowledge sequence
   // ********************
   sequence s_sel_start;
      $fell(o_select_wait_b);
   endsequence
   sequence s_xfer_start;
      $rose(o_select_wait_b) && $fell(o_response_in_progress_b);
   endsequence

   a_wait_then_rip: assert property (s_sel_start |=> s_xfer_start)
      else $error("select wait not followed by response in progress");
   a_rip_ends_wait: assert property ($fell(o_response_in_progress_b) |-> $past(!o_select_wait_b))
      else $error("response started without select wait");
   a_wait_by_ack: assert property (s_sel_start |-> !i_ack_strobe_b && i_cs_b)
      else $error("select wait without acknowledge");
   a_rip_hold_ack: assert property ($rose(o_response_in_progress_b) |-> i_ack_strobe_b)
      else $error("response ended during acknowledge pulse");

   // ********************
   // Bus and outputs
   // ********************
   a_read_drive: assert property ((!i_cs_b && !i_rd_b) |=> !o_data_oe_b)
      else $error("read not driven onto bus");
   a_oe_has_cause: assert property (!o_data_oe_b |-> $past(!i_cs_b && !i_rd_b)
         || !o_response_in_progress_b || $past(!o_response_in_progress_b))
      else $error("bus driven without read or acknowledge");
   a_chain_gated: assert property (o_chain_enable_out |-> i_chain_enable_in)
      else $error("chain out high with chain in low");
   a_irq_drive: assert property (o_group_irq_out |-> !o_group_irq_oe_b)
      else $error("group irq high but not driven");
   a_reset_idle: assert property ($rose(i_rst_b) |-> o_data_oe_b && o_select_wait_b
         && o_response_in_progress_b && o_group_irq_oe_b && !o_chain_enable_out)
      else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// >>> test/vic_host_model.sv
// Host CPU model issuing bus cycles and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none
module vic_host_model (
   // Clock
   input wire logic i_sys_clk,
   // Device answers
   input wire logic [7:0] i_dout,
   input wire logic i_dout_oe_b,
   // Bus strobes
   output logic o_cs_b,
   output logic o_cd,
   output logic o_rd_b,
   output logic o_wr_b,
   output logic [7:0] o_data,
   output logic o_ack_b
);
   initial begin
      o_cs_b = 1'b1;
      o_cd = 1'b1;
      o_rd_b = 1'b1;
      o_wr_b = 1'b1;
      o_data = 8'h00;
      o_ack_b = 1'b1;
   end

   // Released data lines carry the inverse of the last byte
   task automatic wr(input logic cd, input logic [7:0] d);
      @(posedge i_sys_clk);
      #1;
      o_cs_b = 1'b0;
      o_cd = cd;
      o_data = d;
      o_wr_b = 1'b0;
      @(posedge i_sys_clk);
      #1;
      o_wr_b = 1'b1;
      o_cs_b = 1'b1;
      o_data = ~d;
      @(posedge i_sys_clk);
      #1;
   endtask

   task automatic rd(input logic cd, output logic [7:0] d);
      @(posedge i_sys_clk);
      #1;
      o_cs_b = 1'b0;
      o_cd = cd;
      o_rd_b = 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
      d = (i_dout_oe_b === 1'b0) ? i_dout : 8'hxx;
      o_rd_b = 1'b1;
      o_cs_b = 1'b1;
      @(posedge i_sys_clk);
      #1;
   endtask

   // Pulse is long enough to cross the synchroniser both ways
   task automatic ack(output logic [7:0] d);
      @(posedge i_sys_clk);
      #1;
      o_ack_b = 1'b0;
      repeat (6) @(posedge i_sys_clk);
      #1;
      d = (i_dout_oe_b === 1'b0) ? i_dout : 8'hxx;
      o_ack_b = 1'b1;
      repeat (6) @(posedge i_sys_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// >>> test/test_vic_top.sv
// Self-checking bench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module test_vic_top;
   // ********************
   // Signals
   // ********************
   logic i_sys_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_cs_b, i_cd, i_rd_b, i_wr_b, i_ack_strobe_b;
   logic [7:0] i_data, o_data, rd_val;
   logic o_data_oe_b, o_select_wait_b, o_response_in_progress_b;
   logic [7:0] i_request_in = 8'h00;
   logic o_group_irq_out, o_group_irq_oe_b, o_chain_enable_out;
   logic i_chain_enable_in = 1'b1;
   logic i_clk_en = 1'b1;
   int n_errors = 0;
   int n_tests = 0;
   // Command or data byte with control/data select on top
   localparam logic [8:0] INIT [13] = '{9'h198, 9'h1c0, 9'h001, 9'h1e8, 9'h040, 9'h041,
      9'h1e3, 9'h043, 9'h1e5, 9'h045, 9'h1b0, 9'h000, 9'h1a1};

   always #2.5 i_sys_clk = ~i_sys_clk;

   vic_top u_dut (
      .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en),
      .i_cs_b(i_cs_b), .i_cd(i_cd), .i_rd_b(i_rd_b), .i_wr_b(i_wr_b), .i_data(i_data),
      .o_data(o_data), .o_data_oe_b(o_data_oe_b), .i_ack_strobe_b(i_ack_strobe_b),
      .o_select_wait_b(o_select_wait_b), .o_response_in_progress_b(o_response_in_progress_b),
      .i_request_in(i_request_in), .o_group_irq_out(o_group_irq_out),
      .o_group_irq_oe_b(o_group_irq_oe_b), .i_chain_enable_in(i_chain_enable_in),
      .o_chain_enable_out(o_chain_enable_out));

   vic_host_model u_host (
      .i_sys_clk(i_sys_clk), .i_dout(o_data), .i_dout_oe_b(o_data_oe_b), .o_cs_b(i_cs_b),
      .o_cd(i_cd), .o_rd_b(i_rd_b), .o_wr_b(i_wr_b), .o_data(i_data),
      .o_ack_b(i_ack_strobe_b));

   // ********************
   // Helpers
   // ********************
   task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t byte expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic chk_bit(input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t bit expected %b got %b", $time, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] d);
      u_host.wr(1'b1, d);
   endtask
   task automatic chk_reg(input logic [1:0] sel, input logic [7:0] exp);
      cmd(8'ha0 | {4'h0, sel, 2'h0});
      u_host.rd(1'b0, rd_val);
      chk_byte(exp, rd_val);
   endtask
   task automatic chk_stat(input logic [7:0] exp);
      u_host.rd(1'b1, rd_val);
      chk_byte(exp, rd_val & 8'hf8);
   endtask
   task automatic chk_ack(input logic [7:0] exp);
      u_host.ack(rd_val);
      chk_byte(exp, rd_val);
   endtask
   // Toggle request lines and restore them, then let the latch settle
   task automatic req(input logic [7:0] m);
      @(posedge i_sys_clk);
      #1;
      i_request_in = i_request_in ^ m;
      repeat (8) @(posedge i_sys_clk);
      #1;
      i_request_in = i_request_in ^ m;
      repeat (8) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic finish_test();
      $display("n_errors %0d n_tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic t_reset_state();
      chk_bit(1'b1, o_group_irq_oe_b);
      chk_bit(1'b0, o_chain_enable_out);
      chk_stat(8'h40);
      u_host.rd(1'b0, rd_val);
      chk_byte(8'h00, rd_val);
      u_host.wr(1'b0, 8'h55);
      chk_reg(vic_pkg::RD_IMR, 8'hff);
   endtask
   task automatic t_init();
      foreach (INIT[i]) u_host.wr(INIT[i][8], INIT[i][7:0]);
      chk_stat(8'h48);
      chk_bit(1'b1, o_chain_enable_out);
   endtask
   task automatic t_nest();
      req(8'h20);
      chk_bit(1'b1, o_group_irq_out);
      chk_reg(vic_pkg::RD_IRR, 8'h20);
      chk_ack(8'h45);
      chk_bit(1'b1, o_response_in_progress_b);
      chk_reg(vic_pkg::RD_ISR, 8'h20);
      chk_reg(vic_pkg::RD_IRR, 8'h00);
      chk_bit(1'b0, o_group_irq_out);
      req(8'h08);
      chk_bit(1'b1, o_group_irq_out);
      chk_ack(8'h43);
      chk_reg(vic_pkg::RD_ISR, 8'h28);
      req(8'h01);
      chk_ack(8'h40);
      chk_bit(1'b0, o_response_in_progress_b);
      chk_ack(8'h41);
      chk_reg(vic_pkg::RD_ISR, 8'h28);
      chk_reg(vic_pkg::RD_ACR, 8'h01);
      cmd(8'h60);
      chk_reg(vic_pkg::RD_ISR, 8'h20);
      cmd(8'h7d);
      chk_reg(vic_pkg::RD_ISR, 8'h00);
   endtask
   task automatic t_priority();
      req(8'h28);
      chk_ack(8'h43);
      cmd(8'h70);
      cmd(8'h99);
      req(8'h01);
      chk_ack(8'h45);
      cmd(8'h70);
      chk_ack(8'h40);
      chk_ack(8'h41);
      chk_stat(8'h58);
      cmd(8'h9a);
      req(8'h20);
      chk_ack(8'h40);
      chk_ack(8'h41);
      chk_bit(1'b1, o_response_in_progress_b);
      cmd(8'h70);
   endtask
   task automatic t_polled();
      cmd(8'h9c);
      req(8'h20);
      chk_bit(1'b0, o_group_irq_out);
      chk_ack(8'h45);
      chk_reg(vic_pkg::RD_IRR, 8'h20);
      cmd(8'ha2);
      i_chain_enable_in = 1'b0;
      @(posedge i_sys_clk);
      #1;
      chk_bit(1'b0, o_chain_enable_out);
      i_chain_enable_in = 1'b1;
      @(posedge i_sys_clk);
      #1;
      chk_bit(1'b1, o_chain_enable_out);
      cmd(8'h98);
      chk_bit(1'b0, o_chain_enable_out);
      chk_bit(1'b0, o_group_irq_out);
      chk_reg(vic_pkg::RD_IMR, 8'h00);
      chk_stat(8'h40);
   endtask
   // Pending and mask commands, then a write lost while the clock enable is low
   task automatic t_cmds();
      cmd(8'h5b);
      chk_reg(vic_pkg::RD_IRR, 8'h28);
      cmd(8'h4d);
      chk_reg(vic_pkg::RD_IRR, 8'h08);
      cmd(8'h30);
      cmd(8'h2a);
      chk_reg(vic_pkg::RD_IMR, 8'hfb);
      cmd(8'h50);
      cmd(8'h1b);
      chk_reg(vic_pkg::RD_IRR, 8'hf7);
      chk_reg(vic_pkg::RD_IMR, 8'hf3);
      cmd(8'h3b);
      cmd(8'h20);
      chk_reg(vic_pkg::RD_IMR, 8'h00);
      cmd(8'h13);
      chk_reg(vic_pkg::RD_IRR, 8'h00);
      i_clk_en = 1'b0;
      cmd(8'h5f);
      i_clk_en = 1'b1;
      chk_reg(vic_pkg::RD_IRR, 8'h00);
   endtask
   task automatic t_sense();
      cmd(8'h00);
      t_reset_state();
      i_request_in = 8'hff;
      cmd(8'hb0);
      u_host.wr(1'b0, 8'h00);
      cmd(8'ha1);
      req(8'h20);
      chk_bit(1'b0, o_group_irq_oe_b);
      chk_bit(1'b0, o_group_irq_out);
      cmd(8'h88);
      chk_bit(1'b1, o_group_irq_out);
      chk_bit(1'b0, o_group_irq_oe_b);
   endtask

   initial begin
      repeat (12) @(posedge i_sys_clk);
      #1;
      i_rst_b = 1'b1;
      t_reset_state();
      t_init();
      t_nest();
      t_priority();
      t_polled();
      t_cmds();
      t_sense();
      finish_test();
   end

   initial begin
      #50000;
      n_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule

bind vic_top vic_top_asserts #(.N_REQ(N_REQ)) u_chk (
   .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_rd_b(i_rd_b),
   .i_ack_strobe_b(i_ack_strobe_b), .i_chain_enable_in(i_chain_enable_in),
   .o_data_oe_b(o_data_oe_b), .o_select_wait_b(o_select_wait_b),
   .o_response_in_progress_b(o_response_in_progress_b), .o_group_irq_out(o_group_irq_out),
   .o_group_irq_oe_b(o_group_irq_oe_b), .o_chain_enable_out(o_chain_enable_out));
`default_nettype wire
